// >>> rtl/cmic_core.sv
// Cell monitor I2C slave: byte engine, registers, wake filter, bus timeout and pin drivers
// Function
// - Read: master writes register address, then reads the byte held there.
// - First byte after START: seven address bits, then direction, one is read.
// - Acknowledge the address byte only when it matches the fixed slave address.
// - Two 8-bit registers at zero and one, both zero after reset.
// - Bit 7 zero keeps normal operation, one starts sleep.
// - While wake status is one, sleep stays zero and sleep writes are ignored.
// - Wake input high over 10 us sets wake status and clears sleep.
// - Wake status clears at once when the wake input falls.
// - Master may write wake one, acting on sleep like a pin wake.
// - Reading the wake bit shows only the pin-detected state.
// - Bit 5 enables the monitor; bits 4 and 3 are plain storage.
// - Bits 2 to 0 select cell tap code plus one when enabled.
// - Eight active-low divider controls: selected one low, all high when disabled.
// - Each balance bit enables its switch, bit 7 highest cell.
// - Balance enables are independent, any combination allowed.
// - Balance stays on until zero written or sleep accepted, which clears all.
// - Primary discharge gate high only with sleep zero and its control high.
// - Secondary discharge gate high only with sleep zero and its control high.
// - Write: START, address with write, register byte, data byte, STOP.
// - Bus timeout from START, restarted per SCL fall, releases lines on expiry.
// - Accepted sleep command shuts down the divider, monitor, balance and gate outputs; SDA keeps answering the bus.
`timescale 1ns/1ps
`default_nettype none
module cmic_core #(
   parameter int unsigned TOUT_SHORT_CYC = cmic_pkg::TOUT_SHORT_CYC,
   parameter int unsigned TOUT_LONG_CYC  = cmic_pkg::TOUT_LONG_CYC
) (
   input  wire logic       I_MCLK,
   input  wire logic       I_RST_N,
   input  wire logic       I_SCL,
   input  wire logic       I_SDA,
   input  wire logic       I_HIGH_VOLTAGE_WAKE_IN,
   input  wire logic       I_PRIMARY_DISCHARGE_CTRL_IN,
   input  wire logic       I_SECONDARY_DISCHARGE_CTRL_IN,
   input  wire logic       I_TOUT_LONG_SEL,
   output logic            O_SDA,
   output logic            O_SDA_OE_N,
   output logic [7:0]      O_DIVIDER_SWITCH_CONTROLS_N,
   output logic            O_MONITOR_OUTPUT_EN,
   output logic [7:0]      O_BALANCE_SW,
   output logic            O_PRIMARY_DISCHARGE_GATE,
   output logic            O_SECONDARY_DISCHARGE_GATE,
   output logic            O_SLEEP_REQUEST
);
   localparam int TW = cmic_pkg::TOUT_W;
   localparam int WW = cmic_pkg::WAKE_W;

   cmic_sense_if bus ();

   cmic_pkg::cmic_state_t st_q;
   logic [3:0]    cnt_q;
   logic [7:0]    shreg_q;
   logic [7:0]    txd_q;
   logic [7:0]    ptr_q;
   logic          rw_q;
   logic          nack_q;
   logic          sda_oe_n_q;
   logic          wr_q;
   logic [7:0]    wr_data_q;
   logic          sleep_q;
   logic          pin_wake_q;
   logic          wake_wr_q;
   logic [5:0]    ctl_q;
   logic [7:0]    bal_q;
   logic [WW-1:0] wake_cnt_q;
   logic [TW-1:0] tout_cnt_q;
   logic [TW-1:0] tout_lim;
   logic          tout;
   logic          wake_eff;
   logic          wr_ctl;
   logic          wr_bal;

   ////////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Active-low one-hot divider select, all high when the monitor is off
   function automatic logic [7:0] div_dec(input logic en, input logic [2:0] sel);
      div_dec = en ? ~(8'h01 << sel) : 8'hFF;
   endfunction : div_dec

   // Read view; the wake bit shows the pin state only
   function automatic logic [7:0] rd_val(input logic [7:0] a, input logic sleep_request, input logic pw,
                                         input logic [5:0] c, input logic [7:0] b);
      if (a == cmic_pkg::SLEEP_MONITOR_CONTROL_OFS) begin
         rd_val = {sleep_request, pw, c};
      end else if (a == cmic_pkg::BALANCE_SWITCH_ENABLE_OFS) begin
         rd_val = b;
      end else begin
         rd_val = 8'h00;
      end
   endfunction : rd_val

   cmic_sense u_sense (
      .i_clk   (I_MCLK),
      .i_rst_n (I_RST_N),
      .i_pins  ({I_TOUT_LONG_SEL, I_SECONDARY_DISCHARGE_CTRL_IN, I_PRIMARY_DISCHARGE_CTRL_IN,
                 I_HIGH_VOLTAGE_WAKE_IN, I_SDA, I_SCL}),
      .bus     (bus)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Bus timeout; the fuse-style select picks the period
   assign tout_lim = bus.tsel ? TW'(TOUT_LONG_CYC) : TW'(TOUT_SHORT_CYC);
   assign tout     = (st_q != cmic_pkg::ST_IDLE) && (tout_cnt_q >= tout_lim);

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         tout_cnt_q <= '0;
      end else if (bus.start || bus.scl_fall || st_q == cmic_pkg::ST_IDLE) begin
         tout_cnt_q <= '0;
      end else begin
         tout_cnt_q <= tout_cnt_q + TW'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Byte engine: sample on SCL rise, change SDA on SCL fall
   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         st_q       <= cmic_pkg::ST_IDLE;
         cnt_q      <= 4'h0;
         shreg_q    <= 8'h00;
         txd_q      <= 8'h00;
         ptr_q      <= 8'h00;
         rw_q       <= 1'b0;
         nack_q     <= 1'b1;
         sda_oe_n_q <= 1'b1;
         wr_q       <= 1'b0;
         wr_data_q  <= 8'h00;
      end else begin
         wr_q <= 1'b0;
         if (bus.start) begin
            st_q       <= cmic_pkg::ST_ADDR;
            cnt_q      <= 4'h0;
            sda_oe_n_q <= 1'b1;
         end else if (bus.stop || tout) begin
            st_q       <= cmic_pkg::ST_IDLE;
            sda_oe_n_q <= 1'b1;
         end else if (bus.scl_rise) begin
            if (st_q == cmic_pkg::ST_ADDR || st_q == cmic_pkg::ST_REG || st_q == cmic_pkg::ST_WDATA) begin
               shreg_q <= {shreg_q[6:0], bus.sda};
               cnt_q   <= cnt_q + 4'h1;
            end else if (st_q == cmic_pkg::ST_MACK) begin
               nack_q <= bus.sda;
            end
         end else if (bus.scl_fall) begin
            case (st_q)
               cmic_pkg::ST_ADDR: begin
                  if (cnt_q == cmic_pkg::BITS_PER_BYTE) begin
                     if (shreg_q[7:1] == cmic_pkg::SLAVE_ADDR) begin
                        st_q       <= cmic_pkg::ST_AACK;
                        sda_oe_n_q <= 1'b0;
                        rw_q       <= shreg_q[0];
                     end else begin
                        st_q <= cmic_pkg::ST_IDLE;
                     end
                  end
               end
               cmic_pkg::ST_AACK: begin
                  if (rw_q) begin
                     // Second phase of a read returns the byte at the stored pointer
                     txd_q      <= {rd_val(ptr_q, sleep_q, pin_wake_q, ctl_q, bal_q)} << 1;
                     sda_oe_n_q <= rd_val(ptr_q, sleep_q, pin_wake_q, ctl_q, bal_q) >> 7 != 8'h00;
                     cnt_q      <= 4'h1;
                     st_q       <= cmic_pkg::ST_RDATA;
                  end else begin
                     sda_oe_n_q <= 1'b1;
                     cnt_q      <= 4'h0;
                     st_q       <= cmic_pkg::ST_REG;
                  end
               end
               cmic_pkg::ST_REG: begin
                  if (cnt_q == cmic_pkg::BITS_PER_BYTE) begin
                     ptr_q      <= shreg_q;
                     sda_oe_n_q <= 1'b0;
                     st_q       <= cmic_pkg::ST_RACK;
                  end
               end
               cmic_pkg::ST_RACK, cmic_pkg::ST_WACK: begin
                  sda_oe_n_q <= 1'b1;
                  cnt_q      <= 4'h0;
                  st_q       <= cmic_pkg::ST_WDATA;
               end
               cmic_pkg::ST_WDATA: begin
                  if (cnt_q == cmic_pkg::BITS_PER_BYTE) begin
                     wr_q       <= 1'b1;
                     wr_data_q  <= shreg_q;
                     sda_oe_n_q <= 1'b0;
                     st_q       <= cmic_pkg::ST_WACK;
                  end
               end
               cmic_pkg::ST_RDATA: begin
                  if (cnt_q == cmic_pkg::BITS_PER_BYTE) begin
                     sda_oe_n_q <= 1'b1;
                     st_q       <= cmic_pkg::ST_MACK;
                  end else begin
                     sda_oe_n_q <= txd_q[7];
                     txd_q      <= {txd_q[6:0], 1'b0};
                     cnt_q      <= cnt_q + 4'h1;
                  end
               end
               cmic_pkg::ST_MACK: begin
                  // A master ACK asks for the same register again
                  if (nack_q) begin
                     st_q <= cmic_pkg::ST_IDLE;
                  end else begin
                     txd_q      <= {rd_val(ptr_q, sleep_q, pin_wake_q, ctl_q, bal_q)} << 1;
                     sda_oe_n_q <= rd_val(ptr_q, sleep_q, pin_wake_q, ctl_q, bal_q) >> 7 != 8'h00;
                     cnt_q      <= 4'h1;
                     st_q       <= cmic_pkg::ST_RDATA;
                  end
               end
               default: begin
                  st_q <= st_q;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Wake filter; the sampler adds a few cycles but no extra filtering on release
   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         wake_cnt_q <= '0;
         pin_wake_q <= 1'b0;
      end else if (!bus.wake) begin
         wake_cnt_q <= '0;
         pin_wake_q <= 1'b0;
      end else if (wake_cnt_q == WW'(cmic_pkg::WAKE_CYC)) begin
         pin_wake_q <= 1'b1;
      end else begin
         wake_cnt_q <= wake_cnt_q + WW'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   assign wr_ctl   = wr_q && ptr_q == cmic_pkg::SLEEP_MONITOR_CONTROL_OFS;
   assign wr_bal   = wr_q && ptr_q == cmic_pkg::BALANCE_SWITCH_ENABLE_OFS;
   // A written wake takes effect together with the sleep bit of the same write
   assign wake_eff = pin_wake_q || (wr_ctl ? wr_data_q[cmic_pkg::WAKE_BIT] : wake_wr_q);

   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         ctl_q     <= cmic_pkg::REG_RESET[5:0];
         wake_wr_q <= 1'b0;
      end else if (wr_ctl) begin
         ctl_q     <= wr_data_q[cmic_pkg::MON_BIT:0];
         wake_wr_q <= wr_data_q[cmic_pkg::WAKE_BIT];
      end
   end

   // Wake beats any sleep command, including one in the same cycle
   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         sleep_q <= 1'b0;
      end else if (wake_eff) begin
         sleep_q <= 1'b0;
      end else if (wr_ctl) begin
         sleep_q <= wr_data_q[cmic_pkg::SLEEP_BIT];
      end
   end

   // Each bit is its own switch; an accepted sleep clears them all
   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         bal_q <= cmic_pkg::REG_RESET;
      end else if (sleep_q) begin
         bal_q <= 8'h00;
      end else if (wr_bal) begin
         bal_q <= wr_data_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registered pin drivers; sleep shuts the divider, monitor, balance and gate outputs down, SDA keeps working
   always_ff @(posedge I_MCLK) begin
      if (!I_RST_N) begin
         O_SDA                       <= 1'b0;
         O_SDA_OE_N                  <= 1'b1;
         O_DIVIDER_SWITCH_CONTROLS_N <= 8'hFF;
         O_MONITOR_OUTPUT_EN         <= 1'b0;
         O_BALANCE_SW                <= 8'h00;
         O_PRIMARY_DISCHARGE_GATE    <= 1'b0;
         O_SECONDARY_DISCHARGE_GATE  <= 1'b0;
         O_SLEEP_REQUEST             <= 1'b0;
      end else begin
         O_SDA                       <= 1'b0;
         O_SDA_OE_N                  <= sda_oe_n_q;
         O_DIVIDER_SWITCH_CONTROLS_N <= div_dec(ctl_q[cmic_pkg::MON_BIT] && !sleep_q,
                                                ctl_q[cmic_pkg::SEL_HI:0]);
         O_MONITOR_OUTPUT_EN         <= ctl_q[cmic_pkg::MON_BIT] && !sleep_q;
         O_BALANCE_SW                <= sleep_q ? 8'h00 : bal_q;
         O_PRIMARY_DISCHARGE_GATE    <= !sleep_q && bus.dn0;
         O_SECONDARY_DISCHARGE_GATE  <= !sleep_q && bus.dn1;
         O_SLEEP_REQUEST             <= sleep_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (!I_RST_N);

   a_div_select: assert property (ctl_q[cmic_pkg::MON_BIT] && !sleep_q |=>
      O_DIVIDER_SWITCH_CONTROLS_N == ~(8'h01 << $past(ctl_q[2:0])))
      else $error("divider select not one-hot low");
   a_div_off: assert property (!ctl_q[cmic_pkg::MON_BIT] |=> O_DIVIDER_SWITCH_CONTROLS_N == 8'hFF)
      else $error("divider controls not all high when disabled");
   a_wake_holds: assert property (wake_eff |=> !sleep_q)
      else $error("sleep set while wake active");
   a_wake_filter: assert property ($rose(pin_wake_q) |-> $past(wake_cnt_q) == WW'(cmic_pkg::WAKE_CYC))
      else $error("wake status set before filter time");
   a_wake_release: assert property (!bus.wake |=> !pin_wake_q)
      else $error("wake status not cleared on input fall");
   a_bal_sleep: assert property (sleep_q |=> bal_q == 8'h00 ##1 O_BALANCE_SW == 8'h00)
      else $error("balance not cleared by sleep");
   a_gate_main: assert property (O_PRIMARY_DISCHARGE_GATE == $past(!sleep_q && bus.dn0))
      else $error("primary gate mismatch");
   a_gate_second: assert property (O_SECONDARY_DISCHARGE_GATE == $past(!sleep_q && bus.dn1))
      else $error("secondary gate mismatch");
   a_addr_ack: assert property (st_q == cmic_pkg::ST_AACK |->
      !sda_oe_n_q && shreg_q[7:1] == cmic_pkg::SLAVE_ADDR)
      else $error("address acknowledge without match");
   a_tout_idle: assert property (tout && !bus.start |=> st_q == cmic_pkg::ST_IDLE && sda_oe_n_q)
      else $error("timeout did not release bus");

   c_write_done: cover property (wr_ctl ##1 !wake_eff);
   c_read_byte: cover property (st_q == cmic_pkg::ST_RDATA ##[1:200] st_q == cmic_pkg::ST_MACK);
   c_pin_wake: cover property ($rose(pin_wake_q));
   c_sleep: cover property ($rose(sleep_q));

endmodule : cmic_core
`default_nettype wire

// >>> rtl/cmic_pkg.sv
// Constants, register map, field layout and state codes of the cell monitor I2C control block
package cmic_pkg;

   // Clock and timing
   localparam int unsigned CLK_KHZ        = 125000;
   localparam int unsigned TOUT_SHORT_MS  = 32;
   localparam int unsigned TOUT_LONG_MS   = 64;
   localparam int unsigned TOUT_SHORT_CYC = TOUT_SHORT_MS * CLK_KHZ;
   localparam int unsigned TOUT_LONG_CYC  = TOUT_LONG_MS * CLK_KHZ;
   localparam int unsigned TOUT_W         = 24;
   localparam int unsigned WAKE_NS        = 10000;
   localparam int unsigned WAKE_CYC       = WAKE_NS * (CLK_KHZ / 1000) / 1000;
   localparam int unsigned WAKE_W         = 11;

   // Bus addressing
   localparam logic [6:0] SLAVE_ADDR = 7'h5C;
   localparam logic [7:0] SLEEP_MONITOR_CONTROL_OFS = 8'h00;
   localparam logic [7:0] BALANCE_SWITCH_ENABLE_OFS = 8'h01;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Fields of the sleep and monitor control register
   localparam int unsigned SLEEP_BIT = 7;
   localparam int unsigned WAKE_BIT  = 6;
   localparam int unsigned MON_BIT   = 5;
   localparam int unsigned RSV_HI    = 4;
   localparam int unsigned SEL_HI    = 2;

   // Positions of the pins inside the synchroniser vector
   localparam int unsigned PIN_SCL  = 0;
   localparam int unsigned PIN_SDA  = 1;
   localparam int unsigned PIN_WAKE = 2;
   localparam int unsigned PIN_DN0  = 3;
   localparam int unsigned PIN_DN1  = 4;
   localparam int unsigned PIN_TSEL = 5;
   localparam int unsigned PIN_N    = 6;

   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Byte engine states
   typedef enum logic [8:0] {
      ST_IDLE  = 9'h001,
      ST_ADDR  = 9'h002,
      ST_AACK  = 9'h004,
      ST_REG   = 9'h008,
      ST_RACK  = 9'h010,
      ST_WDATA = 9'h020,
      ST_WACK  = 9'h040,
      ST_RDATA = 9'h080,
      ST_MACK  = 9'h100
   } cmic_state_t;

endpackage : cmic_pkg

// >>> rtl/cmic_sense.sv
// Pin sampler: three-stage synchronisers, agreement filter and I2C event detection
`timescale 1ns/1ps
`default_nettype none
module cmic_sense (
   input  wire logic                       i_clk,
   input  wire logic                       i_rst_n,
   input  wire logic [cmic_pkg::PIN_N-1:0] i_pins,
   cmic_sense_if.sense                     bus
);
   localparam int N = cmic_pkg::PIN_N;

   logic [N-1:0] s1_q;
   logic [N-1:0] s2_q;
   logic [N-1:0] s3_q;
   logic [N-1:0] filt_q;
   logic [N-1:0] prev_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Synchroniser chain; the bus idles high, so SCL and SDA reset to one
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s1_q <= 6'h03;
         s2_q <= 6'h03;
         s3_q <= 6'h03;
      end else begin
         s1_q <= i_pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A level is accepted only once stages two and three agree
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         filt_q <= 6'h03;
         prev_q <= 6'h03;
      end else begin
         filt_q <= (s2_q == s3_q) ? s2_q : filt_q;
         prev_q <= filt_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Levels and one-cycle events
   assign bus.scl  = filt_q[cmic_pkg::PIN_SCL];
   assign bus.sda  = filt_q[cmic_pkg::PIN_SDA];
   assign bus.wake = filt_q[cmic_pkg::PIN_WAKE];
   assign bus.dn0  = filt_q[cmic_pkg::PIN_DN0];
   assign bus.dn1  = filt_q[cmic_pkg::PIN_DN1];
   assign bus.tsel = filt_q[cmic_pkg::PIN_TSEL];
   assign bus.scl_rise = filt_q[cmic_pkg::PIN_SCL] & ~prev_q[cmic_pkg::PIN_SCL];
   assign bus.scl_fall = ~filt_q[cmic_pkg::PIN_SCL] & prev_q[cmic_pkg::PIN_SCL];
   // SDA moving while SCL is held high marks START or STOP
   assign bus.start = filt_q[cmic_pkg::PIN_SCL] & prev_q[cmic_pkg::PIN_SCL]
                    & ~filt_q[cmic_pkg::PIN_SDA] & prev_q[cmic_pkg::PIN_SDA];
   assign bus.stop  = filt_q[cmic_pkg::PIN_SCL] & prev_q[cmic_pkg::PIN_SCL]
                    & filt_q[cmic_pkg::PIN_SDA] & ~prev_q[cmic_pkg::PIN_SDA];

endmodule : cmic_sense
`default_nettype wire

// >>> rtl/cmic_sense_if.sv
// Filtered pin levels and bus events passed from the pin sampler to the core
`timescale 1ns/1ps
`default_nettype none
interface cmic_sense_if;
   logic scl;
   logic sda;
   logic wake;
   logic dn0;
   logic dn1;
   logic tsel;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   modport sense (output scl, sda, wake, dn0, dn1, tsel, scl_rise, scl_fall, start, stop);
   modport core  (input  scl, sda, wake, dn0, dn1, tsel, scl_rise, scl_fall, start, stop);
endinterface : cmic_sense_if
`default_nettype wire

// >>> sim/cmic_core_test.sv
// Self-checking bench: registers, outputs, wake filter and bus timeout
`timescale 1ns/1ps
`default_nettype none
module cmic_core_test;
   localparam int LIMIT = 80000;
   logic       mclk, rst_n, wake, dn0, dn1, tsel, ok, oe_n, mon, g0, g1, sleep_request, sda_o;
   wire logic  scl, rel, sda;
   logic [7:0] div_n, bal, rv;
   logic [7:0] ab = 8'hB8;
   int         n_mismatch, n_checks, cyc;
   // Open drain: either party pulls the line low; the device drives O_SDA, always zero, while enabled
   assign sda = rel & (oe_n | sda_o);
   cmic_core #(.TOUT_SHORT_CYC(2000), .TOUT_LONG_CYC(4000)) DUT (
      .I_MCLK(mclk), .I_RST_N(rst_n), .I_SCL(scl), .I_SDA(sda), .I_HIGH_VOLTAGE_WAKE_IN(wake),
      .I_PRIMARY_DISCHARGE_CTRL_IN(dn0), .I_SECONDARY_DISCHARGE_CTRL_IN(dn1), .I_TOUT_LONG_SEL(tsel),
      .O_SDA(sda_o), .O_SDA_OE_N(oe_n), .O_DIVIDER_SWITCH_CONTROLS_N(div_n), .O_MONITOR_OUTPUT_EN(mon),
      .O_BALANCE_SW(bal), .O_PRIMARY_DISCHARGE_GATE(g0), .O_SECONDARY_DISCHARGE_GATE(g1), .O_SLEEP_REQUEST(sleep_request));
   cmic_master u_master (.o_scl(scl), .o_rel(rel), .i_sda(sda));
   initial mclk = 1'b0;
   always #4 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] r, input logic [7:0] d);
      u_master.wr(7'h5C, r, d, ok);
      chk({7'h00, ok}, 8'h01);
   endtask : wr
   task automatic rd(input logic [7:0] r, input logic [7:0] exp);
      u_master.rd(7'h5C, r, rv, ok);
      chk({7'h00, ok}, 8'h01);
      chk(rv, exp);
   endtask : rd
   // Flags packed as monitor, gate 0, gate 1, sleep
   task automatic outs(input logic [7:0] d, input logic [7:0] b, input logic [3:0] f);
      chk(div_n, d);
      chk(bal, b);
      chk({4'h0, mon, g0, g1, sleep_request}, {4'h0, f});
   endtask : outs
   task automatic pins(input logic w, input logic a, input logic b, input int n);
      @(posedge mclk);
      #1 wake = w;
      dn0 = a;
      dn1 = b;
      repeat (n) @(posedge mclk);
      // Leave off the edge so outputs are settled and the link keeps its one-step offset
      #1;
   endtask : pins
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test
   // Hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_mismatch++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n = 1'b0;
      wake = 1'b0;
      dn0 = 1'b0;
      dn1 = 1'b0;
      tsel = 1'b0;
      repeat (10) @(posedge mclk);
      #1 rst_n = 1'b1;
      repeat (5) @(posedge mclk);
      #1 outs(8'hFF, 8'h00, 4'h0);
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h00);
      u_master.wr(7'h5D, 8'h01, 8'hFF, ok);
      chk({7'h00, ok}, 8'h00);
      rd(8'h01, 8'h00);
      $display("test reset done");
      for (int s = 0; s < 8; s++) begin
         wr(8'h00, 8'h20 | s[7:0]);
         outs(8'hFF ^ (8'h01 << s), 8'h00, 4'h8);
      end
      wr(8'h00, 8'h1F);
      outs(8'hFF, 8'h00, 4'h0);
      rd(8'h00, 8'h1F);
      $display("test monitor done");
      wr(8'h01, 8'hA5);
      rd(8'h01, 8'hA5);
      wr(8'h05, 8'hFF);
      rd(8'h05, 8'h00);
      pins(1'b0, 1'b1, 1'b1, 10);
      outs(8'hFF, 8'hA5, 4'h6);
      wr(8'h00, 8'hA0);
      outs(8'hFF, 8'h00, 4'h1);
      rd(8'h01, 8'h00);
      rd(8'h00, 8'hA0);
      $display("test balance and sleep done");
      // A pulse below the filter length must not wake
      pins(1'b1, 1'b1, 1'b1, 1000);
      outs(8'hFF, 8'h00, 4'h1);
      pins(1'b0, 1'b1, 1'b1, 10);
      pins(1'b1, 1'b1, 1'b1, 1300);
      outs(8'hFE, 8'h00, 4'hE);
      rd(8'h00, 8'h60);
      wr(8'h00, 8'hA0);
      outs(8'hFE, 8'h00, 4'hE);
      pins(1'b0, 1'b1, 1'b1, 3);
      rd(8'h00, 8'h20);
      wr(8'h00, 8'h80);
      outs(8'hFF, 8'h00, 4'h1);
      wr(8'h00, 8'h40);
      outs(8'hFF, 8'h00, 4'h6);
      rd(8'h00, 8'h00);
      wr(8'h00, 8'h00);
      wr(8'h00, 8'h80);
      outs(8'hFF, 8'h00, 4'h1);
      wr(8'h00, 8'h00);
      $display("test wake done");
      // Stall with the acknowledge held low until the timeout frees the line
      for (int t = 0; t < 2; t++) begin
         @(posedge mclk);
         #1 tsel = t[0];
         u_master.start();
         for (int i = 7; i >= 0; i--) u_master.tx(ab[i]);
         repeat (20) @(posedge mclk);
         #1 chk({7'h00, oe_n}, 8'h00);
         repeat (1900 + 2000 * t) @(posedge mclk);
         #1 chk({7'h00, oe_n}, 8'h00);
         repeat (200) @(posedge mclk);
         #1 chk({7'h00, oe_n}, 8'h01);
         u_master.stop();
      end
      rd(8'h00, 8'h00);
      $display("test timeout done");
      end_of_test();
   end
endmodule : cmic_core_test
`default_nettype wire

// >>> sim/cmic_master.sv
// I2C master model standing in for the companion controller
`timescale 1ns/1ps
`default_nettype none
module cmic_master (
   output var logic o_scl,
   output var logic o_rel,
   input  wire logic i_sda
);
   // Fifth of a bit slot; the low phase is kept well above the pin filter delay
   localparam int Q = 32;
   initial begin
      o_scl = 1'b1;
      o_rel = 1'b1;
   end
   // One bit out: data moves only while the clock is low
   task automatic tx(input logic b);
      #Q o_rel = b;
      #(2*Q) o_scl = 1'b1;
      #(2*Q) o_scl = 1'b0;
   endtask : tx
   // One bit in, taken halfway through the high phase with the line released
   task automatic rx(output logic b);
      #Q o_rel = 1'b1;
      #(2*Q) o_scl = 1'b1;
      #Q b = i_sda;
      #Q o_scl = 1'b0;
   endtask : rx
   task automatic start;
      #Q o_rel = 1'b1;
      #Q o_scl = 1'b1;
      #(2*Q) o_rel = 1'b0;
      #(2*Q) o_scl = 1'b0;
   endtask : start
   // Clock stands high and data released after the frame
   task automatic stop;
      #Q o_rel = 1'b0;
      #Q o_scl = 1'b1;
      #(2*Q) o_rel = 1'b1;
      #(4*Q);
   endtask : stop
   // Byte goes MSB first; ok is high when the ninth bit was pulled low
   task automatic byte_tx(input logic [7:0] v, output logic ok);
      logic a;
      for (int i = 7; i >= 0; i--) tx(v[i]);
      rx(a);
      ok = ~a;
   endtask : byte_tx
   task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d, output logic ok);
      logic k0, k1, k2;
      start();
      byte_tx({a, 1'b0}, k0);
      byte_tx(r, k1);
      byte_tx(d, k2);
      stop();
      ok = k0 & k1 & k2;
   endtask : wr
   // Two stages: register address written, then the byte fetched
   task automatic rd(input logic [6:0] a, input logic [7:0] r, output logic [7:0] d, output logic ok);
      logic k0, k1, k2, b;
      start();
      byte_tx({a, 1'b0}, k0);
      byte_tx(r, k1);
      stop();
      start();
      byte_tx({a, 1'b1}, k2);
      for (int i = 7; i >= 0; i--) begin
         rx(b);
         d[i] = b;
      end
      tx(1'b1);
      stop();
      ok = k0 & k1 & k2;
   endtask : rd
endmodule : cmic_master
`default_nettype wire
